// ==== hw/adc_scan_sequencer.sv ====
// Summary of operation
// - One multiplexed converter is shared by eight channels, 12-bit results.
// - Channels 1-4 external; 5-8 internal diagnostic sources on the mux.
// - Bipolar ranges read signed -2048..2047; unipolar ranges 0..4095.
// - Each channel may serve feedback, plain conversion, or both.
// - Software reads the latest value of any selected channel.
// - Any channel may feed any axis; no fixed pairing.
// - Feedback values are absolute positions within converter full scale.
// - Per-channel enable; disabled channels are skipped in the scan.
// - Scan fast enough to refresh feedback every fastest servo update.
// - Fastest servo period is 250 us; staleness flagged beyond it.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_regs.svh"

module adc_scan_sequencer
	import adc_scan_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [2:0] ADC_MUX_SEL,
	output logic [1:0] ADC_RANGE,
	output logic ADC_START,
	input wire logic ADC_DONE,
	input wire logic [11:0] ADC_CODE
);

	// ==========================================
	// Helpers
	function automatic logic [31:0] fmt_result(input logic [11:0] code,
		input range_type rng);
		if (rng == RANGE_BIP10 || rng == RANGE_BIP5) begin
			fmt_result = {{20{code[11]}}, code};
		end else begin
			fmt_result = {20'h00000, code};
		end
	endfunction

	function automatic logic [31:0] wr_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			wr_merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ==========================================
	// Registers
	logic [31:0] cfg_ff, nxt_cfg;
	logic [31:0] map_ff, nxt_map;
	logic [2:0] sel_ff, nxt_sel;
	logic [11:0] res_ff [`NUM_CHAN];
	logic [`NUM_CHAN-1:0] fresh_ff, nxt_fresh;
	logic [`NUM_CHAN-1:0] en;
	range_type rng [`NUM_CHAN];

	always_comb begin
		en = cfg_ff[`CFG_EN_LSB +: `NUM_CHAN];
		for (int i = 0; i < `NUM_CHAN; i++) begin
			rng[i] = range_type'(cfg_ff[`CFG_RANGE_LSB + 2*i +: 2]);
		end
	end

	// ==========================================
	// Scan sequencer
	scan_state_type st_ff, nxt_st;
	logic [2:0] ch_ff, nxt_ch;
	logic start_ff, nxt_start;
	logic [2:0] mux_ff, nxt_mux;
	logic [1:0] arng_ff, nxt_arng;
	logic fifo_in_ready, fifo_out_valid;
	sample_type fifo_in, fifo_out;

	function automatic logic [2:0] next_en(input logic [2:0] cur,
		input logic [7:0] mask);
		logic [2:0] c;
		c = cur;
		next_en = cur;
		for (int k = 1; k <= `NUM_CHAN; k++) begin
			c = 3'(cur + 3'(k));
			if (mask[c] && next_en == cur) begin
				next_en = c;
			end
		end
	endfunction

	always_comb begin
		nxt_st = st_ff;
		nxt_ch = ch_ff;
		nxt_start = 1'b0;
		nxt_mux = mux_ff;
		nxt_arng = arng_ff;
		case (st_ff)
			SCAN_IDLE: begin
				if (en != '0) begin
					nxt_ch = en[ch_ff] ? ch_ff : next_en(ch_ff, en);
					nxt_st = SCAN_START;
				end
			end
			SCAN_START: begin
				if (!en[ch_ff]) begin
					nxt_st = SCAN_IDLE;
				end else if (fifo_in_ready) begin
					nxt_mux = ch_ff;
					nxt_arng = rng[ch_ff];
					nxt_start = 1'b1;
					nxt_st = SCAN_WAIT;
				end
			end
			SCAN_WAIT: begin
				if (ADC_DONE && !start_ff) begin
					nxt_ch = next_en(ch_ff, en);
					nxt_st = (en == '0) ? SCAN_IDLE : SCAN_START;
				end
			end
			default: nxt_st = SCAN_IDLE;
		endcase
	end

	assign fifo_in.chan = mux_ff;
	assign fifo_in.code = ADC_CODE;

	sample_fifo #(.WIDTH($bits(sample_type)), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk(CLK_SYS),
		.rst(RST),
		.in_data(fifo_in),
		.in_valid(st_ff == SCAN_WAIT && ADC_DONE && !start_ff),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1)
	);

	// ==========================================
	// Staleness watchdog per channel
	logic [14:0] age_ff [`NUM_CHAN];
	logic [14:0] nxt_age [`NUM_CHAN];
	logic [`NUM_CHAN-1:0] stale;

	always_comb begin
		nxt_fresh = fresh_ff;
		for (int i = 0; i < `NUM_CHAN; i++) begin
			stale[i] = en[i] && (age_ff[i] >= 15'(`SERVO_CYCLES));
			nxt_age[i] = stale[i] ? age_ff[i] : age_ff[i] + 15'h0001;
			if (fifo_out_valid && fifo_out.chan == 3'(i)) begin
				nxt_age[i] = 15'h0000;
				nxt_fresh[i] = 1'b1;
			end
		end
	end

	// ==========================================
	// AXI4-Lite slave
	logic awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv;
	logic [7:0] awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd;
	logic [3:0] ws_ff, nxt_ws;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rv_ff, nxt_rv;
	logic [31:0] rd_ff, nxt_rd;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [31:0] rdat;
	logic rhit;

	function automatic logic [31:0] axis_fb(input int ax);
		logic [2:0] c;
		c = map_ff[4*ax +: 3];
		axis_fb = fmt_result(res_ff[c], rng[c]);
	endfunction

	always_comb begin
		rhit = 1'b1;
		rdat = 32'h0000_0000;
		if (S_AXI_ARADDR == `REG_CHAN_CFG) begin
			rdat = cfg_ff;
		end else if (S_AXI_ARADDR == `REG_AXIS_MAP) begin
			rdat = map_ff;
		end else if (S_AXI_ARADDR == `REG_RESULT_SEL) begin
			rdat = {29'h0, sel_ff};
		end else if (S_AXI_ARADDR == `REG_RESULT) begin
			rdat = fmt_result(res_ff[sel_ff], rng[sel_ff]);
		end else if (S_AXI_ARADDR == `REG_SCAN_STATUS) begin
			rdat = {13'h0, ch_ff, stale, fresh_ff};
		end else if (S_AXI_ARADDR == `REG_AXIS_FB0) begin
			rdat = axis_fb(0);
		end else if (S_AXI_ARADDR == `REG_AXIS_FB1) begin
			rdat = axis_fb(1);
		end else if (S_AXI_ARADDR == `REG_AXIS_FB2) begin
			rdat = axis_fb(2);
		end else if (S_AXI_ARADDR == `REG_AXIS_FB3) begin
			rdat = axis_fb(3);
		end else begin
			rhit = 1'b0;
		end
	end

	always_comb begin
		nxt_awr = awr_ff;
		nxt_wr = wr_ff;
		nxt_awa = awa_ff;
		nxt_wd = wd_ff;
		nxt_ws = ws_ff;
		nxt_bv = bv_ff;
		nxt_bresp = bresp_ff;
		nxt_cfg = cfg_ff;
		nxt_map = map_ff;
		nxt_sel = sel_ff;
		nxt_rv = rv_ff;
		nxt_rd = rd_ff;
		nxt_rresp = rresp_ff;
		if (S_AXI_AWVALID && !awr_ff && !bv_ff) begin
			nxt_awr = 1'b1;
			nxt_awa = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !wr_ff && !bv_ff) begin
			nxt_wr = 1'b1;
			nxt_wd = S_AXI_WDATA;
			nxt_ws = S_AXI_WSTRB;
		end
		if (awr_ff && wr_ff) begin
			nxt_awr = 1'b0;
			nxt_wr = 1'b0;
			nxt_bv = 1'b1;
			nxt_bresp = `RESP_OKAY;
			if (awa_ff == `REG_CHAN_CFG) begin
				nxt_cfg = wr_merge(cfg_ff, wd_ff, ws_ff);
			end else if (awa_ff == `REG_AXIS_MAP) begin
				nxt_map = wr_merge(map_ff, wd_ff, ws_ff);
			end else if (awa_ff == `REG_RESULT_SEL) begin
				if (ws_ff[0]) begin
					nxt_sel = wd_ff[2:0];
				end
			end else begin
				nxt_bresp = `RESP_SLVERR;
			end
		end
		if (bv_ff && S_AXI_BREADY) begin
			nxt_bv = 1'b0;
		end
		if (S_AXI_ARVALID && !rv_ff) begin
			nxt_rv = 1'b1;
			nxt_rd = rdat;
			nxt_rresp = rhit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rv_ff && S_AXI_RREADY) begin
			nxt_rv = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_ff <= SCAN_IDLE;
			ch_ff <= '0;
			start_ff <= 1'b0;
			mux_ff <= '0;
			arng_ff <= '0;
			cfg_ff <= `CFG_RESET;
			map_ff <= `AXIS_MAP_RESET;
			sel_ff <= '0;
			fresh_ff <= '0;
			awr_ff <= 1'b0;
			wr_ff <= 1'b0;
			awa_ff <= '0;
			wd_ff <= '0;
			ws_ff <= '0;
			bv_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
			rv_ff <= 1'b0;
			rd_ff <= '0;
			rresp_ff <= `RESP_OKAY;
			for (int i = 0; i < `NUM_CHAN; i++) begin
				res_ff[i] <= '0;
				age_ff[i] <= '0;
			end
		end else begin
			st_ff <= nxt_st;
			ch_ff <= nxt_ch;
			start_ff <= nxt_start;
			mux_ff <= nxt_mux;
			arng_ff <= nxt_arng;
			cfg_ff <= nxt_cfg;
			map_ff <= nxt_map;
			sel_ff <= nxt_sel;
			fresh_ff <= nxt_fresh;
			awr_ff <= nxt_awr;
			wr_ff <= nxt_wr;
			awa_ff <= nxt_awa;
			wd_ff <= nxt_wd;
			ws_ff <= nxt_ws;
			bv_ff <= nxt_bv;
			bresp_ff <= nxt_bresp;
			rv_ff <= nxt_rv;
			rd_ff <= nxt_rd;
			rresp_ff <= nxt_rresp;
			for (int i = 0; i < `NUM_CHAN; i++) begin
				age_ff[i] <= nxt_age[i];
				if (fifo_out_valid && fifo_out.chan == 3'(i)) begin
					res_ff[i] <= fifo_out.code;
				end
			end
		end
	end

	assign S_AXI_AWREADY = awr_ff;
	assign S_AXI_WREADY = wr_ff;
	assign S_AXI_BVALID = bv_ff;
	assign S_AXI_BRESP = bresp_ff;
	assign S_AXI_ARREADY = rv_ff;
	assign S_AXI_RVALID = rv_ff;
	assign S_AXI_RDATA = rd_ff;
	assign S_AXI_RRESP = rresp_ff;
	assign ADC_MUX_SEL = mux_ff;
	assign ADC_RANGE = arng_ff;
	assign ADC_START = start_ff;

endmodule

`default_nettype wire

// ==== hw/adc_scan_regs.svh ====
`ifndef ADC_SCAN_REGS_SVH
`define ADC_SCAN_REGS_SVH

// ==========================================
// Register byte offsets
`define REG_CHAN_CFG 8'h00
`define REG_AXIS_MAP 8'h04
`define REG_RESULT_SEL 8'h08
`define REG_RESULT 8'h0C
`define REG_SCAN_STATUS 8'h10
`define REG_AXIS_FB0 8'h14
`define REG_AXIS_FB1 8'h18
`define REG_AXIS_FB2 8'h1C
`define REG_AXIS_FB3 8'h20

// ==========================================
// Field layout and reset values
`define CFG_EN_LSB 0
`define CFG_RANGE_LSB 8
`define CFG_FB_LSB 24
`define CFG_CONV_LSB 28
`define CFG_RESET 32'h0000_0000
`define AXIS_MAP_RESET 32'h0000_0000
`define NUM_CHAN 8
`define NUM_AXIS 4
`define FIFO_DEPTH 8

// ==========================================
// Timing
`define SERVO_PERIOD_NS 250000
`define CLK_PERIOD_NS 10
`define SERVO_CYCLES (`SERVO_PERIOD_NS / `CLK_PERIOD_NS)

// ==========================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/adc_scan_pkg.sv ====
package adc_scan_pkg;

	typedef enum logic [1:0] {
		RANGE_BIP10,
		RANGE_BIP5,
		RANGE_UNI10,
		RANGE_UNI5
	} range_type;

	typedef struct packed {
		logic [2:0] chan;
		logic [11:0] code;
	} sample_type;

	typedef enum {
		SCAN_IDLE,
		SCAN_START,
		SCAN_WAIT
	} scan_state_type;

endpackage

// ==== hw/sample_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		nxt_wr = push ? wr_ff + AW'(1) : wr_ff;
		nxt_rd = pop ? rd_ff + AW'(1) : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
endmodule

`default_nettype wire

// ==== tb/adc_scan_sequencer_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none

module adc_scan_checker (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [2:0] ADC_MUX_SEL,
	input wire logic [1:0] ADC_RANGE,
	input wire logic ADC_START,
	input wire logic ADC_DONE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// ====
	// Conversion in flight
	logic busy_ff;
	logic nxt_busy;
	always_comb begin
		nxt_busy = busy_ff;
		if (ADC_START)
			nxt_busy = 1'h1;
		else if (ADC_DONE)
			nxt_busy = 1'h0;
	end
	always_ff @(posedge CLK_SYS) begin
		busy_ff <= RST ? 1'h0 : nxt_busy;
	end

	sequence wr_offer;
		S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
	endsequence
	sequence rd_open;
		S_AXI_ARVALID && !S_AXI_RVALID;
	endsequence

	start_pulse_a: assert property (ADC_START |=> !ADC_START)
		else $error("start longer than one cycle");
	one_conv_a: assert property (ADC_START |-> !busy_ff)
		else $error("start while converting");
	mux_hold_a: assert property (
		!ADC_START |-> $stable({ADC_MUX_SEL, ADC_RANGE}))
		else $error("mux or range moved between starts");
	wr_answer_a: assert property (wr_offer |-> ##[1:4] S_AXI_BVALID)
		else $error("write response late");
	b_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response stuck");
	rd_answer_a: assert property (rd_open |=> S_AXI_RVALID)
		else $error("read data late");
	r_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
		else $error("read data stuck");
	r_cause_a: assert property ($rose(S_AXI_RVALID) |-> $past(S_AXI_ARVALID))
		else $error("read data without a request");
	aw_ack_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
		else $error("awready longer than one cycle");
endmodule

`default_nettype wire

// ==== tb/adc_front_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module adc_front_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [2:0] mux,
	input wire logic slow,
	input wire logic stall,
	output logic done,
	output logic [11:0] code
);
	logic [4:0] cnt;
	// ====
	// Code line toggles outside the done cycle
	always @(posedge clk) begin
		done <= 1'h0;
		code <= ~code;
		if (rst) begin
			cnt <= 5'h00;
			code <= 12'h000;
		end else if (start) begin
			cnt <= slow ? 5'h14 : 5'h03;
		end else if (cnt != 5'h00 && !stall) begin
			cnt <= cnt - 5'h01;
			if (cnt == 5'h01) begin
				done <= 1'h1;
				code <= {mux, 9'h1F0};
			end
		end
	end
endmodule

`default_nettype wire

// ==== tb/adc_scan_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_scan_regs.svh"

module adc_scan_sequencer_bench import adc_scan_pkg::*;;
	logic CLK_SYS = 1'h0;
	logic RST = 1'h1;
	logic [7:0] S_AXI_AWADDR = 8'h00;
	logic [7:0] S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = 1'h0;
	logic S_AXI_WVALID = 1'h0;
	logic S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0;
	logic S_AXI_RREADY = 1'h0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, ADC_START, ADC_DONE;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, ADC_RANGE;
	logic [31:0] S_AXI_RDATA;
	logic [2:0] ADC_MUX_SEL;
	logic [11:0] ADC_CODE;
	logic slow = 1'h0;
	logic stall = 1'h0;
	int err_count = 0;
	int compares = 0;
	logic [2:0] mq[$];
	logic [1:0] rq[$];
	logic [31:0] cfg, d;
	logic [31:0] exp_val;
	logic [2:0] ch;

	always #5 CLK_SYS = ~CLK_SYS;
	adc_scan_sequencer DUT (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY),
		.ADC_MUX_SEL(ADC_MUX_SEL),
		.ADC_RANGE(ADC_RANGE),
		.ADC_START(ADC_START),
		.ADC_DONE(ADC_DONE),
		.ADC_CODE(ADC_CODE)
	);
	adc_front_model conv (
		.clk(CLK_SYS),
		.rst(RST),
		.start(ADC_START),
		.mux(ADC_MUX_SEL),
		.slow(slow),
		.stall(stall),
		.done(ADC_DONE),
		.code(ADC_CODE)
	);
	always @(posedge CLK_SYS) begin
		if (ADC_START === 1'h1) begin
			mq.push_back(ADC_MUX_SEL);
			rq.push_back(ADC_RANGE);
		end
	end

	// ====
	// Bus cycles and checks
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] er);
		@(posedge CLK_SYS);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= v;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do begin
			@(posedge CLK_SYS);
			if (S_AXI_AWREADY === 1'h1) S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY === 1'h1) S_AXI_WVALID <= 1'h0;
		end while (S_AXI_BVALID !== 1'h1);
		S_AXI_BREADY <= 1'h0;
		chk("bresp", er, S_AXI_BRESP);
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] e, input logic [1:0] er);
		@(posedge CLK_SYS);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do begin
			@(posedge CLK_SYS);
			if (S_AXI_ARREADY === 1'h1) S_AXI_ARVALID <= 1'h0;
		end while (S_AXI_RVALID !== 1'h1);
		S_AXI_RREADY <= 1'h0;
		d = S_AXI_RDATA;
		chk(n, e, d);
		chk("rresp", er, S_AXI_RRESP);
	endtask
	function automatic logic [31:0] fmt(input logic [2:0] c,
		input logic [1:0] g);
		logic [11:0] v;
		v = {c, 9'h1F0};
		return g[1] ? {20'h0, v} : {{20{v[11]}}, v};
	endfunction
	function automatic logic [2:0] nxt(input logic [2:0] n,
		input logic [7:0] en);
		logic [2:0] k;
		k = n + 3'h1;
		while (!en[k]) k = k + 3'h1;
		return k;
	endfunction
	task automatic scan_chk(input logic [31:0] c);
		repeat (30) @(posedge CLK_SYS);
		mq.delete();
		rq.delete();
		repeat (300) @(posedge CLK_SYS);
		for (int i = 0; i < 6; i++) begin
			chk("next channel", nxt(mq[i], c[7:0]), mq[i + 1]);
			chk("range", c[8 + 2 * mq[i] +: 2], rq[i]);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ====
	// Tests
	initial begin
		repeat (10) @(posedge CLK_SYS);
		RST <= 1'h0;
		rchk("cfg", `REG_CHAN_CFG, `CFG_RESET, `RESP_OKAY);
		rchk("map", `REG_AXIS_MAP, `AXIS_MAP_RESET, `RESP_OKAY);
		chk("idle starts", 0, mq.size());
		wr(8'h40, 32'h1, 4'hF, `RESP_SLVERR);
		wr(`REG_RESULT, 32'h1, 4'hF, `RESP_SLVERR);
		rchk("unmapped", 8'h40, 32'h0, `RESP_SLVERR);
		cfg = 32'hA5C1_8099;
		wr(`REG_CHAN_CFG, cfg, 4'hF, `RESP_OKAY);
		rchk("cfg", `REG_CHAN_CFG, cfg, `RESP_OKAY);
		scan_chk(cfg);
		for (int i = 0; i < 8; i++) begin
			if (cfg[i]) begin
				wr(`REG_RESULT_SEL, i, 4'h1, `RESP_OKAY);
				exp_val = fmt(3'(i), cfg[8 + 2 * i +: 2]);
				rchk("result", `REG_RESULT, exp_val, `RESP_OKAY);
			end
		end
		// Freeze the scan so the current channel is the last one started
		stall <= 1'h1;
		repeat (40) @(posedge CLK_SYS);
		exp_val = {13'h0, mq[$], 8'h00, 8'h99};
		rchk("status", `REG_SCAN_STATUS, exp_val, `RESP_OKAY);
		stall <= 1'h0;
		slow <= 1'h1;
		wr(`REG_AXIS_MAP, 32'h3047, 4'hF, `RESP_OKAY);
		scan_chk(cfg);
		for (int i = 0; i < 4; i++) begin
			ch = 3'(32'h3047 >> (4 * i));
			exp_val = fmt(ch, cfg[8 + 2 * ch +: 2]);
			rchk("feedback", 8'(`REG_AXIS_FB0 + 4 * i), exp_val,
				`RESP_OKAY);
		end
		// Hung converter: every enabled channel must go stale
		stall <= 1'h1;
		repeat (`SERVO_CYCLES + 100) @(posedge CLK_SYS);
		exp_val = {13'h0, mq[$], 8'h99, 8'h99};
		rchk("stale", `REG_SCAN_STATUS, exp_val, `RESP_OKAY);
		stall <= 1'h0;
		repeat (150) @(posedge CLK_SYS);
		stall <= 1'h1;
		repeat (60) @(posedge CLK_SYS);
		exp_val = {13'h0, mq[$], 8'h00, 8'h99};
		rchk("stale cleared", `REG_SCAN_STATUS, exp_val,
			`RESP_OKAY);
		stall <= 1'h0;
		wr(`REG_CHAN_CFG, 32'hFFFF_FF01, 4'h1, `RESP_OKAY);
		cfg = {cfg[31:8], 8'h01};
		rchk("cfg strobe", `REG_CHAN_CFG, cfg, `RESP_OKAY);
		scan_chk(cfg);
		wr(`REG_CHAN_CFG, 32'h0, 4'hF, `RESP_OKAY);
		repeat (40) @(posedge CLK_SYS);
		mq.delete();
		repeat (100) @(posedge CLK_SYS);
		chk("halted starts", 0, mq.size());
		rchk("idle status", `REG_SCAN_STATUS, 32'h0000_0099,
			`RESP_OKAY);
		report_and_stop();
	end

	initial begin
		#500000;
		err_count++;
		report_and_stop();
	end
endmodule

bind adc_scan_sequencer adc_scan_checker chk_i (
	.CLK_SYS(CLK_SYS),
	.RST(RST),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_RDATA(S_AXI_RDATA),
	.ADC_MUX_SEL(ADC_MUX_SEL),
	.ADC_RANGE(ADC_RANGE),
	.ADC_START(ADC_START),
	.ADC_DONE(ADC_DONE)
);

`default_nettype wire
